// ==== common/lpmw_pkg.sv ====
package lpmw_pkg;
    // clock and cycle conversion
    localparam int CLK_NS = 10;
    function automatic int cyc_least(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int cyc_most(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // times in ns
    localparam int T_LP_WAKE_NS = 150_000;
    localparam int T_START_NS = 1_000_000;
    localparam int T_SETTLE_NS = 3_800_000;
    localparam int T_COLD_NS = 1_900_000;
    localparam int T_ACC_NS = 250_000;
    localparam int T_ALERT_NS = 10_000;
    localparam int T_TRACK_NS = 1_150;
    localparam int T_ON_MIN_NS = 250_000;

    // times in cycles and counter widths
    localparam int LP_WAKE_CYC = cyc_least(T_LP_WAKE_NS);
    localparam int START_CYC = cyc_least(T_START_NS);
    localparam int SETTLE_CYC = cyc_least(T_SETTLE_NS);
    localparam int COLD_CYC = cyc_least(T_COLD_NS);
    localparam int ACC_CYC = cyc_most(T_ACC_NS);
    localparam int ALERT_CYC = cyc_least(T_ALERT_NS);
    localparam int TRACK_CYC = cyc_least(T_TRACK_NS);
    localparam int ON_MIN_CYC = cyc_least(T_ON_MIN_NS);
    localparam int TMR_W = 20;
    localparam int TRK_W = 8;
    localparam int ALERT_W = 11;

    // widths
    localparam int ANGLE_W = 8;
    localparam int GAIN_W = 6;
    localparam int TURN_W = 8;
    localparam int CODE_W = 5;
    localparam int DATA_W = 8;
    localparam int OTP_W = 9;
    localparam int TRIM_W = 8;
    localparam int OTP_WAKE_EN_BIT = 8;
    localparam logic [ANGLE_W-1:0] HALF_TURN = 8'h80;

    // serial commands
    localparam logic [CODE_W-1:0] CMD_WRITE_CONFIG = 5'h17;
    localparam logic [CODE_W-1:0] CMD_TRIM_RELOAD = 5'h13;
    localparam logic [CODE_W-1:0] CMD_STORE_REF = 5'h03;
    localparam logic [CODE_W-1:0] CMD_CUST_SETTINGS = 5'h1f;
    localparam int CFG_LOW_POWER_BIT = 0;
    localparam int CFG_GAIN_WAIT_BIT = 1;

    // controller register map
    localparam int AXI_ADDR_W = 4;
    localparam logic [AXI_ADDR_W-1:0] REG_CMD = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] REG_POWER = 4'h4;
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_DATA_LSB = 8;
    localparam int PWR_MAIN_BIT = 0;
    localparam int PWR_RET_BIT = 1;
    localparam int PWR_SUP_OK_BIT = 2;
    localparam int ST_ANGLE_LSB = 0;
    localparam int ST_LOCK_BIT = 8;
    localparam int ST_WAKE_BIT = 9;
    localparam int ST_MAIN_BIT = 10;
    localparam int ST_PEND_BIT = 11;
    localparam int ST_READY_BIT = 12;
    localparam int ST_TURNS_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        DEV_OFF, DEV_START, DEV_ACTIVE, DEV_LOWPWR, DEV_RESUME
    } lpmw_state_t;
endpackage

// ==== common/lpmw_if.sv ====
`timescale 1ns/10ps
interface lpmw_if
    import lpmw_pkg::*;
();
    logic main_power;
    logic retention_supply;
    logic supply_ok;
    logic cmd_valid;
    logic [CODE_W-1:0] cmd_code;
    logic [DATA_W-1:0] cmd_data;
    logic [ANGLE_W-1:0] angle;
    logic lock;
    logic [TURN_W-1:0] turns;
    logic meas_ready;
    logic wake_o;
    logic wake_drive_n;
    wire wake_n;

    // open-drain wake line with pull-up
    assign wake_n = wake_drive_n ? 1'b1 : wake_o;

    modport sensor (
        input main_power, retention_supply, supply_ok, cmd_valid, cmd_code, cmd_data,
        output angle, lock, turns, meas_ready, wake_o, wake_drive_n
    );
    modport ctrl (
        output main_power, retention_supply, supply_ok, cmd_valid, cmd_code, cmd_data,
        input angle, lock, turns, meas_ready, wake_n
    );
endinterface

// ==== logic/lpmw_sensor.sv ====
`timescale 1ns/10ps
module lpmw_sensor
    import lpmw_pkg::*;
#(
    parameter int P_LP_WAKE_CYC = LP_WAKE_CYC,
    parameter int P_START_CYC = START_CYC,
    parameter int P_SETTLE_CYC = SETTLE_CYC,
    parameter int P_COLD_CYC = COLD_CYC,
    parameter int P_ACC_CYC = ACC_CYC
)(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    lpmw_if.sensor link,
    input wire logic [ANGLE_W-1:0] magnet_angle_in,
    input wire logic [GAIN_W-1:0] magnet_gain_in,
    input wire logic [OTP_W-1:0] otp_word_in,
    output logic [ANGLE_W-1:0] angle_out,
    output logic lock_out,
    output logic settled_out
);
    // shortest distance around the code circle
    function automatic logic [ANGLE_W-1:0] ang_dist(input logic [ANGLE_W-1:0] a,
                                                     input logic [ANGLE_W-1:0] b);
        logic [ANGLE_W-1:0] d;
        d = a - b;
        return (d > HALF_TURN) ? ANGLE_W'(b - a) : d;
    endfunction

    lpmw_state_t state_reg, state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TRK_W-1:0] trk_div_reg;
    logic polling_reg, gain_wait_reg, settled_reg, ready_reg;
    logic [ANGLE_W-1:0] pos_reg;
    logic [GAIN_W-1:0] gain_reg;
    logic [TURN_W-1:0] turns_reg;
    logic lock_reg;
    logic [TRIM_W-1:0] trim_reg;
    logic [ANGLE_W-1:0] thr_reg;
    logic ret_en_reg, ref_valid_reg;
    logic [ANGLE_W-1:0] ret_pos_reg, ret_thr_reg, ref_reg;
    logic [GAIN_W-1:0] ret_gain_reg;
    logic [TURN_W-1:0] ret_turns_reg;
    logic [TRIM_W-1:0] ret_trim_reg;
    logic [ALERT_W-1:0] alert_cnt_reg;
    logic wake_drive_n_reg;

    // command decode
    wire powered = state_reg != DEV_OFF;
    wire running = (state_reg == DEV_START) || (state_reg == DEV_RESUME)
                   || (state_reg == DEV_ACTIVE);
    wire cmd_on = link.cmd_valid && powered;
    wire cfg_wr = cmd_on && (link.cmd_code == CMD_WRITE_CONFIG);
    wire cfg_lp = link.cmd_data[CFG_LOW_POWER_BIT];
    wire trim_wr = cmd_on && (link.cmd_code == CMD_TRIM_RELOAD);
    wire ref_wr = cmd_on && (link.cmd_code == CMD_STORE_REF);
    wire cust_wr = cmd_on && (link.cmd_code == CMD_CUST_SETTINGS);
    wire wake_fuse = otp_word_in[OTP_WAKE_EN_BIT];
    wire power_up = (state_reg == DEV_OFF) && link.main_power;

    // timing decode
    wire [TMR_W-1:0] start_wait = polling_reg ? TMR_W'(P_ACC_CYC) : TMR_W'(P_COLD_CYC);
    wire [TMR_W-1:0] settle_wait = gain_wait_reg ? TMR_W'(P_SETTLE_CYC)
                                                 : TMR_W'(P_START_CYC);
    wire start_done = (state_reg == DEV_START) && (tmr_reg == start_wait - 1'b1);
    wire resume_done = (state_reg == DEV_RESUME)
                       && (tmr_reg == TMR_W'(P_LP_WAKE_CYC - 1));
    wire trk_tick = running && (trk_div_reg == TRK_W'(TRACK_CYC - 1));

    // tracking step decode
    wire [ANGLE_W-1:0] fwd = magnet_angle_in - pos_reg;
    wire step_up = fwd < HALF_TURN;
    wire at_target = pos_reg == magnet_angle_in;
    wire [ANGLE_W-1:0] pos_up = pos_reg + 1'b1;
    wire [ANGLE_W-1:0] pos_dn = pos_reg - 1'b1;
    wire wrap_up = step_up && (pos_reg == {ANGLE_W{1'b1}});
    wire wrap_dn = !step_up && (pos_reg == '0);

    // motion decision at the end of a polled start
    wire moved = !ref_valid_reg || (ang_dist(pos_reg, ref_reg) > thr_reg);
    wire fire_alert = start_done && polling_reg && moved;

    // power mode sequencing
    always_comb begin
        state_next = state_reg;
        if (!link.main_power) begin
            state_next = DEV_OFF;
        end else begin
            unique case (state_reg)
                DEV_OFF: state_next = DEV_START;
                DEV_START: if (start_done) state_next = DEV_ACTIVE;
                DEV_ACTIVE: if (cfg_wr && cfg_lp) state_next = DEV_LOWPWR;
                DEV_LOWPWR: if (cfg_wr && !cfg_lp) state_next = DEV_RESUME;
                DEV_RESUME: if (resume_done) state_next = DEV_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg <= DEV_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // startup timer, frozen in low power
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || power_up || (state_next == DEV_RESUME && state_reg != DEV_RESUME)) begin
            tmr_reg <= '0;
        end else if (running && tmr_reg != {TMR_W{1'b1}}) begin
            tmr_reg <= tmr_reg + 1'b1;
        end
    end

    // tracking rate divider
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !running || trk_tick) begin
            trk_div_reg <= '0;
        end else begin
            trk_div_reg <= trk_div_reg + 1'b1;
        end
    end

    // start kind, settling and readiness flags
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            polling_reg <= 1'b0;
            gain_wait_reg <= 1'b0;
            settled_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            if (power_up) begin
                polling_reg <= ret_en_reg;
                settled_reg <= 1'b0;
            end else if (running && tmr_reg >= settle_wait - 1'b1) begin
                settled_reg <= 1'b1;
            end
            if (cfg_wr) begin
                gain_wait_reg <= link.cmd_data[CFG_GAIN_WAIT_BIT];
            end
            ready_reg <= state_next == DEV_ACTIVE;
        end
    end

    // live state: restore or zero at power-up, tracking frozen outside running, trim and threshold writable whenever powered
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pos_reg <= '0;
            gain_reg <= '0;
            turns_reg <= '0;
            lock_reg <= 1'b0;
            trim_reg <= '0;
            thr_reg <= '0;
        end else if (power_up) begin
            pos_reg <= ret_en_reg ? ret_pos_reg : '0;
            gain_reg <= ret_en_reg ? ret_gain_reg : '0;
            turns_reg <= ret_en_reg ? ret_turns_reg : '0;
            trim_reg <= ret_en_reg ? ret_trim_reg : '0;
            thr_reg <= ret_en_reg ? ret_thr_reg : '0;
            lock_reg <= 1'b0;
        end else begin
            if (trk_tick) begin
                if (!at_target) begin
                    pos_reg <= step_up ? pos_up : pos_dn;
                end
                if (!at_target && wrap_up) begin
                    turns_reg <= turns_reg + 1'b1;
                end else if (!at_target && wrap_dn) begin
                    turns_reg <= turns_reg - 1'b1;
                end
                if (gain_reg < magnet_gain_in) begin
                    gain_reg <= gain_reg + 1'b1;
                end else if (gain_reg > magnet_gain_in) begin
                    gain_reg <= gain_reg - 1'b1;
                end
                lock_reg <= at_target;
            end
            if (trim_wr) begin
                trim_reg <= otp_word_in[TRIM_W-1:0];
            end
            if (cust_wr) begin
                thr_reg <= link.cmd_data;
            end
        end
    end

    // retained storage on the retention supply
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !link.retention_supply) begin
            ret_en_reg <= 1'b0;
            ref_valid_reg <= 1'b0;
            ret_pos_reg <= '0;
            ret_gain_reg <= '0;
            ret_turns_reg <= '0;
            ret_trim_reg <= '0;
            ret_thr_reg <= '0;
            ref_reg <= '0;
        end else begin
            if (ret_en_reg && link.supply_ok && running) begin
                ret_pos_reg <= pos_reg;
                ret_gain_reg <= gain_reg;
                ret_turns_reg <= turns_reg;
                ret_trim_reg <= trim_reg;
                ret_thr_reg <= thr_reg;
            end
            if (trim_wr && wake_fuse) begin
                ret_en_reg <= 1'b1;
                ret_trim_reg <= otp_word_in[TRIM_W-1:0];
            end
            if (ref_wr) begin
                ref_reg <= pos_reg;
                ref_valid_reg <= 1'b1;
            end
        end
    end

    // wake pulse, pin released when idle
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !link.main_power) begin
            alert_cnt_reg <= '0;
            wake_drive_n_reg <= 1'b1;
        end else if (fire_alert) begin
            alert_cnt_reg <= ALERT_W'(ALERT_CYC - 1);
            wake_drive_n_reg <= 1'b0;
        end else if (alert_cnt_reg != '0) begin
            alert_cnt_reg <= alert_cnt_reg - 1'b1;
        end else begin
            wake_drive_n_reg <= 1'b1;
        end
    end

    // outputs
    assign link.angle = pos_reg;
    assign link.lock = lock_reg;
    assign link.turns = turns_reg;
    assign link.meas_ready = ready_reg;
    assign link.wake_o = 1'b0;
    assign link.wake_drive_n = wake_drive_n_reg;
    assign angle_out = pos_reg;
    assign lock_out = lock_reg;
    assign settled_out = settled_reg;
endmodule

// ==== logic/lpmw_ctrl.sv ====
`timescale 1ns/10ps
module lpmw_ctrl
    import lpmw_pkg::*;
#(
    parameter int P_ON_MIN_CYC = ON_MIN_CYC,
    parameter int P_LP_WAKE_CYC = LP_WAKE_CYC
)(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    lpmw_if.ctrl link
);
    logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic main_req_reg, main_on_reg, ret_on_reg, sup_ok_reg;
    logic [TMR_W-1:0] on_cnt_reg;
    logic pend_reg, trim_done_reg, wake_seen_reg;
    logic [CODE_W-1:0] pend_code_reg, cmd_code_reg;
    logic [DATA_W-1:0] pend_data_reg, cmd_data_reg;
    logic cmd_valid_reg;

    // write path decode
    wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
    wire wr_go = aw_got_reg && w_got_reg && !bvalid_reg;
    wire wr_en = wr_go && (w_strb_reg != '0);
    wire wr_cmd = wr_en && (aw_addr_reg == REG_CMD) && !pend_reg;
    wire wr_pwr = wr_en && (aw_addr_reg == REG_POWER);
    wire wr_st = wr_en && (aw_addr_reg == REG_STATUS);
    wire wr_ok = (aw_addr_reg == REG_CMD) || (aw_addr_reg == REG_POWER)
                 || (aw_addr_reg == REG_STATUS);
    assign s_axi_awready_out = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready_out = !w_got_reg && !bvalid_reg;

    // read path decode
    wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
    wire [ANGLE_W-1:0] shown_angle = link.lock ? link.angle : '0;
    wire [31:0] status_word = 32'(shown_angle) << ST_ANGLE_LSB
        | 32'(link.lock) << ST_LOCK_BIT | 32'(wake_seen_reg) << ST_WAKE_BIT
        | 32'(main_on_reg) << ST_MAIN_BIT | 32'(pend_reg) << ST_PEND_BIT
        | 32'(link.meas_ready) << ST_READY_BIT | 32'(link.turns) << ST_TURNS_LSB;
    wire [31:0] power_word = 32'(main_req_reg) << PWR_MAIN_BIT
        | 32'(ret_on_reg) << PWR_RET_BIT | 32'(sup_ok_reg) << PWR_SUP_OK_BIT;
    wire rd_st = s_axi_araddr_in == REG_STATUS;
    wire rd_pwr = s_axi_araddr_in == REG_POWER;
    wire rd_cmd = s_axi_araddr_in == REG_CMD;
    assign s_axi_arready_out = !rvalid_reg;

    // command issue decisions
    wire pend_lp = (pend_code_reg == CMD_WRITE_CONFIG) && pend_data_reg[CFG_LOW_POWER_BIT];
    wire pend_wake = (pend_code_reg == CMD_WRITE_CONFIG) && !pend_data_reg[CFG_LOW_POWER_BIT];
    wire dwell_ok = on_cnt_reg >= TMR_W'(P_LP_WAKE_CYC);
    wire link_up = main_on_reg && (on_cnt_reg != '0) && !cmd_valid_reg;
    wire want_trim = main_on_reg && ret_on_reg && !trim_done_reg;
    wire issue_trim = link_up && want_trim;
    wire issue_pend = link_up && !want_trim && pend_reg
                      && (!pend_lp || (dwell_ok && link.lock));
    wire off_ok = on_cnt_reg >= TMR_W'(P_ON_MIN_CYC);

    // register slave handshakes
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (aw_hs) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (w_hs) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_st ? status_word : (rd_pwr ? power_word : '0);
            rresp_reg <= (rd_st || rd_pwr || rd_cmd) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    // supply switching with least on-time
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            main_req_reg <= 1'b0;
            main_on_reg <= 1'b0;
            ret_on_reg <= 1'b0;
            sup_ok_reg <= 1'b0;
            on_cnt_reg <= '0;
        end else begin
            if (wr_pwr) begin
                main_req_reg <= w_data_reg[PWR_MAIN_BIT];
                ret_on_reg <= w_data_reg[PWR_RET_BIT];
                sup_ok_reg <= w_data_reg[PWR_SUP_OK_BIT];
            end
            if (main_req_reg) begin
                main_on_reg <= 1'b1;
            end else if (off_ok) begin
                main_on_reg <= 1'b0;
            end
            if (!main_on_reg || (issue_pend && pend_wake)) begin
                on_cnt_reg <= '0;
            end else if (on_cnt_reg != {TMR_W{1'b1}}) begin
                on_cnt_reg <= on_cnt_reg + 1'b1;
            end
        end
    end

    // command queue and link strobe
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pend_reg <= 1'b0;
            pend_code_reg <= '0;
            pend_data_reg <= '0;
            cmd_valid_reg <= 1'b0;
            cmd_code_reg <= '0;
            cmd_data_reg <= '0;
            trim_done_reg <= 1'b0;
        end else begin
            cmd_valid_reg <= issue_trim || issue_pend;
            if (issue_trim) begin
                cmd_code_reg <= CMD_TRIM_RELOAD;
                cmd_data_reg <= '0;
                trim_done_reg <= 1'b1;
            end else if (issue_pend) begin
                cmd_code_reg <= pend_code_reg;
                cmd_data_reg <= pend_data_reg;
                pend_reg <= 1'b0;
            end
            if (!ret_on_reg) begin
                trim_done_reg <= 1'b0;
            end
            if (wr_cmd) begin
                pend_reg <= 1'b1;
                pend_code_reg <= w_data_reg[CMD_CODE_LSB +: CODE_W];
                pend_data_reg <= w_data_reg[CMD_DATA_LSB +: DATA_W];
            end
        end
    end

    // sticky wake flag, a new wake wins over the clear
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            wake_seen_reg <= 1'b0;
        end else if (!link.wake_n) begin
            wake_seen_reg <= 1'b1;
        end else if (wr_st && w_data_reg[ST_WAKE_BIT]) begin
            wake_seen_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign link.main_power = main_on_reg;
    assign link.retention_supply = ret_on_reg;
    assign link.supply_ok = sup_ok_reg;
    assign link.cmd_valid = cmd_valid_reg;
    assign link.cmd_code = cmd_code_reg;
    assign link.cmd_data = cmd_data_reg;
endmodule

// ==== bench/lpmw_chk.sv ====
`timescale 1ns/10ps
module lpmw_chk
    import lpmw_pkg::*;
#(
    parameter int P_ACC_CYC = ACC_CYC
)(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic main_power,
    input wire logic cmd_valid,
    input wire logic [CODE_W-1:0] cmd_code,
    input wire logic [DATA_W-1:0] cmd_data,
    input wire logic [ANGLE_W-1:0] angle,
    input wire logic meas_ready,
    input wire logic wake_o,
    input wire logic wake_drive_n
);
    int low_cnt, on_cnt;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // alert length and powered time
    always_ff @(posedge sys_clk_in) begin
        low_cnt <= (!nrst_in || wake_drive_n) ? 0 : low_cnt + 1;
        on_cnt <= (!nrst_in || !main_power) ? 0 : on_cnt + 1;
    end
    // low power entry freezes tracking
    sequence s_lp_cmd;
        cmd_valid && cmd_code == CMD_WRITE_CONFIG && cmd_data[CFG_LOW_POWER_BIT] && meas_ready;
    endsequence
    sequence s_frozen;
        (!meas_ready && $stable(angle))[*8];
    endsequence
    property p_lp; s_lp_cmd |=> ##1 s_frozen; endproperty
    property p_len; $rose(wake_drive_n) && $past(main_power) |-> low_cnt == ALERT_CYC; endproperty
    property p_max; low_cnt <= ALERT_CYC; endproperty
    property p_od; wake_o == 1'b0; endproperty
    property p_acc; $fell(wake_drive_n) |-> on_cnt >= P_ACC_CYC; endproperty
    property p_off; !main_power && !$past(main_power) |-> wake_drive_n; endproperty
    property p_step; meas_ready && $past(meas_ready) && $changed(angle) |->
        angle - $past(angle) == 8'h01 || angle - $past(angle) == 8'hff; endproperty
    property p_hold; meas_ready && $changed(angle) |=> $stable(angle)[*8]; endproperty
    a_lp: assert property (p_lp) else $error("state not frozen in low power");
    a_len: assert property (p_len) else $error("alert pulse length wrong");
    a_max: assert property (p_max) else $error("alert pulse too long");
    a_od: assert property (p_od) else $error("alert line driven high");
    a_acc: assert property (p_acc) else $error("alert before accurate angle");
    a_off: assert property (p_off) else $error("alert while unpowered");
    a_step: assert property (p_step) else $error("tracking jumped");
    a_hold: assert property (p_hold) else $error("tracking stepped too fast");
endmodule

// ==== bench/low_power_motion_wake_logic_tb_top.sv ====
`timescale 1ns/10ps
module low_power_motion_wake_logic_tb_top;
    import lpmw_pkg::*;
    logic sys_clk_in = 1'b0, nrst_in = 1'b0;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
    logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out, st;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
    logic [ANGLE_W-1:0] magnet = '0, ang_o;
    logic [GAIN_W-1:0] gain = '0;
    logic [OTP_W-1:0] otp = '0;
    logic lock_o, settled_o;
    int fail_count = 0, n_compared = 0, lfsr = 48535, refa, tgt, thr = 4;
    int deltas[$] = '{4, 5, 251};
    lpmw_if link();
    always #5 sys_clk_in = ~sys_clk_in;
    lpmw_ctrl #(.P_ON_MIN_CYC(60)) lpmw_ctrl_inst (.*);
    lpmw_sensor #(.P_SETTLE_CYC(300), .P_COLD_CYC(200), .P_ACC_CYC(60)) lpmw_sensor_inst (.*,
        .magnet_angle_in(magnet), .magnet_gain_in(gain), .otp_word_in(otp), .angle_out(ang_o),
        .lock_out(lock_o), .settled_out(settled_o));
    lpmw_chk #(.P_ACC_CYC(60)) lpmw_chk_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .main_power(link.main_power), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .cmd_data(link.cmd_data), .angle(link.angle), .meas_ready(link.meas_ready),
        .wake_o(link.wake_o), .wake_drive_n(link.wake_drive_n));
    // comparison, bus cycles and model helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axw(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        rsp = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic axr(input logic [AXI_ADDR_W-1:0] a);
        @(posedge sys_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        st = s_axi_rdata_out;
        rsp = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask
    task automatic wait_st(input int b, input logic v);
        do axr(REG_STATUS); while (st[b] !== v);
    endtask
    task automatic cmd(input logic [4:0] c, input logic [7:0] d);
        axw(REG_CMD, {16'h0000, d, 3'h0, c});
        wait_st(ST_PEND_BIT, 1'b0);
    endtask
    function automatic int wrap_dist(input int a, input int b);
        int d;
        d = (a - b + 256) % 256;
        return (d > 128) ? 256 - d : d;
    endfunction
    // random source
    function automatic int lfsr_next(input int v);
        return 32'({v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]});
    endfunction
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence: cold start, low power, polled wake trials
    initial begin
        repeat (6) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        lfsr = lfsr_next(lfsr);
        magnet <= lfsr[7:0];
        lfsr = lfsr_next(lfsr);
        gain <= lfsr[5:0];
        otp <= {1'b1, lfsr[7:0]}; // wake fuse set for polling
        axr(4'hc);
        chk("unmapped resp", rsp, RESP_SLVERR);
        axw(REG_POWER, 32'h0000_0007);
        wait_st(ST_READY_BIT, 1'b1);
        wait_st(ST_LOCK_BIT, 1'b1);
        chk("cold wake", st[ST_WAKE_BIT], 1'b0);
        chk("angle", st[7:0], magnet);
        chk("angle pin", ang_o, magnet);
        chk("lock pin", lock_o, 1'b1);
        chk("settled cold", settled_o, 1'b0);
        cmd(CMD_STORE_REF, 8'h00);
        cmd(CMD_CUST_SETTINGS, thr[7:0]);
        refa = magnet;
        cmd(CMD_WRITE_CONFIG, 8'h01);
        axr(REG_STATUS);
        chk("low power ready", st[ST_READY_BIT], 1'b0);
        cmd(CMD_WRITE_CONFIG, 8'h02); // resume, gain-settle wait on
        wait_st(ST_READY_BIT, 1'b1);
        chk("resumed angle", st[7:0], refa);
        foreach (deltas[i]) begin
            tgt = (refa + deltas[i]) % 256;
            magnet <= tgt[7:0];
            do axr(REG_STATUS); while (st[7:0] !== tgt[7:0]);
            axw(REG_POWER, 32'h0000_0002);
            wait_st(ST_MAIN_BIT, 1'b0);
            axw(REG_POWER, 32'h0000_0007);
            wait_st(ST_READY_BIT, 1'b1);
            chk("settled early", settled_o, 1'b0);
            axr(REG_STATUS);
            chk("wake seen", st[ST_WAKE_BIT], wrap_dist(tgt, refa) > thr);
            repeat (1100) @(posedge sys_clk_in);
            chk("wake released", link.wake_n, 1'b1);
            chk("settled", settled_o, 1'b1);
            axw(REG_STATUS, 32'h0000_0200);
        end
        finish_test();
    end
    // watchdog
    initial begin
        #900000;
        fail_count++;
        finish_test();
    end
endmodule
